/* core/iccr_regs.sv */
module iccr_regs
    import iccr_pkg::*;
(
    // clock and reset
    input wire logic REF_CLK,
    input wire logic SYS_RST,
    input wire logic CLK_EN,
    // host configuration access
    input wire logic CFG_WR,
    input wire logic CFG_RD,
    input wire logic [7:0] CFG_INDEX,
    input wire logic [7:0] CFG_WDATA,
    output logic [7:0] CFG_RDATA,
    // card side
    input wire logic KEY_MATCHED,
    input wire logic [7:0] CARD_SELECT_NUMBER_IN,
    input wire logic CARD_SELECT_NUMBER_LOAD,
    input wire logic [7:0] RESOURCE_BYTE,
    input wire logic RESOURCE_READY,
    input wire logic [7:0] SERIAL_ID_BYTE,
    output logic [7:0] CARD_SELECT_NUMBER,
    output logic [9:0] READ_PORT_ADDR,
    output logic SERIAL_ID_STEP,
    output logic RESOURCE_ADVANCE,
    output logic RESOURCE_PTR_RESET,
    output logic [NUM_LOGICAL_DEVICES-1:0] DEVICE_RESET,
    output logic [3:0] CARD_STATE
);
    iccr_access_type acc;
    iccr_cmd_type cmd;
    iccr_state_type state_r, state_nxt;
    logic [7:0] read_port_r, read_port_nxt;
    logic [7:0] csn_r, csn_nxt;
    logic [7:0] rdata_nxt;
    logic wr_reloc, wr_ctrl, wr_wake, rd_serial, rd_resource, wake_hit;

    assign acc = '{wr: CFG_WR, rd: CFG_RD, index: CFG_INDEX, data: CFG_WDATA};
    assign wr_reloc = acc.wr && acc.index == IDX_READ_PORT_RELOC;
    assign wr_ctrl = acc.wr && acc.index == IDX_CONFIG_CONTROL;
    assign wr_wake = acc.wr && acc.index == IDX_WAKE;
    // reads only pulse when the card is in the matching state
    assign rd_serial = acc.rd && acc.index == IDX_SERIAL_ID && state_r == ST_ISOLATION;
    assign rd_resource = acc.rd && acc.index == IDX_RESOURCE_DATA && state_r == ST_CONFIG;
    assign wake_hit = wr_wake && acc.data == csn_r;
    // command bits decode as one-shot pulses; nothing is stored
    assign cmd.reset_devices = wr_ctrl && acc.data[CC_RESET_DEV_BIT];
    assign cmd.wait_for_key = wr_ctrl && acc.data[CC_WAIT_KEY_BIT];
    assign cmd.clear_csn = wr_ctrl && acc.data[CC_CLEAR_CSN_BIT];
    // relocation write wins over the reset-devices bit in one write
    assign read_port_nxt = wr_reloc ? acc.data
                         : cmd.reset_devices ? READ_PORT_RESET
                         : read_port_r;

    always_comb begin
        csn_nxt = csn_r;
        if (CARD_SELECT_NUMBER_LOAD) begin
            csn_nxt = CARD_SELECT_NUMBER_IN;
        end
        if (cmd.clear_csn) begin
            csn_nxt = CSN_RESET;
        end
    end

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_WAIT_KEY: begin
                if (KEY_MATCHED) begin
                    state_nxt = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (wake_hit) begin
                    state_nxt = (acc.data == ZERO_BYTE) ? ST_ISOLATION : ST_CONFIG;
                end
            end
            ST_ISOLATION, ST_CONFIG: begin
                if (wr_wake && !wake_hit) begin
                    state_nxt = ST_SLEEP;
                end
            end
            default: state_nxt = ST_WAIT_KEY;
        endcase
        if (cmd.wait_for_key) begin
            state_nxt = ST_WAIT_KEY;
        end
    end

    // read mux: relocation, control and all unlisted indices read zero
    always_comb begin
        rdata_nxt = ZERO_BYTE;
        if (acc.rd) begin
            case (acc.index)
                IDX_SERIAL_ID: rdata_nxt = (state_r == ST_ISOLATION) ? SERIAL_ID_BYTE
                                                                    : ZERO_BYTE;
                IDX_RESOURCE_DATA: rdata_nxt = RESOURCE_BYTE;
                IDX_STATUS: rdata_nxt = {7'h00, RESOURCE_READY};
                default: rdata_nxt = ZERO_BYTE;
            endcase
        end
    end

    // card sequencer state
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            state_r <= ST_WAIT_KEY;
        end else if (CLK_EN) begin
            state_r <= state_nxt;
        end
    end

    // card select number survives device reset and key-wait
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            csn_r <= CSN_RESET;
        end else if (CLK_EN) begin
            csn_r <= csn_nxt;
        end
    end

    // read port relocation register
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            read_port_r <= READ_PORT_RESET;
        end else if (CLK_EN) begin
            read_port_r <= read_port_nxt;
        end
    end

    // registered read data
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            CFG_RDATA <= ZERO_BYTE;
        end else if (CLK_EN) begin
            CFG_RDATA <= rdata_nxt;
        end
    end

    // one-cycle strobes toward the identifier and resource logic
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            SERIAL_ID_STEP <= 1'b0;
            RESOURCE_ADVANCE <= 1'b0;
            RESOURCE_PTR_RESET <= 1'b0;
        end else if (CLK_EN) begin
            SERIAL_ID_STEP <= rd_serial;
            RESOURCE_ADVANCE <= rd_resource && RESOURCE_READY;
            RESOURCE_PTR_RESET <= wake_hit;
        end
    end

    // one reset strobe per logical device
    for (genvar d = 0; d < NUM_LOGICAL_DEVICES; d++) begin : g_dev
        always_ff @(posedge REF_CLK) begin
            if (SYS_RST) begin
                DEVICE_RESET[d] <= 1'b0;
            end else if (CLK_EN) begin
                DEVICE_RESET[d] <= cmd.reset_devices;
            end
        end
    end

    assign CARD_SELECT_NUMBER = csn_r;
    assign READ_PORT_ADDR = {read_port_r, 2'b11};
    assign CARD_STATE = state_r;
endmodule

/* inc/iccr_pkg.sv */
package iccr_pkg;
    // register indices in the card-level span
    localparam logic [7:0] IDX_READ_PORT_RELOC = 8'h00;
    localparam logic [7:0] IDX_SERIAL_ID = 8'h01;
    localparam logic [7:0] IDX_CONFIG_CONTROL = 8'h02;
    localparam logic [7:0] IDX_WAKE = 8'h03;
    localparam logic [7:0] IDX_RESOURCE_DATA = 8'h04;
    localparam logic [7:0] IDX_STATUS = 8'h05;
    localparam logic [7:0] IDX_CARD_LEVEL_LAST = 8'h2f;
    // config control bit positions
    localparam int CC_RESET_DEV_BIT = 0;
    localparam int CC_WAIT_KEY_BIT = 1;
    localparam int CC_CLEAR_CSN_BIT = 2;
    localparam int STATUS_READY_BIT = 0;
    // reset values
    localparam logic [7:0] READ_PORT_RESET = 8'h00;
    localparam logic [7:0] CSN_RESET = 8'h00;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam int NUM_LOGICAL_DEVICES = 2;

    typedef enum logic [3:0] {
        ST_WAIT_KEY = 4'b0001,
        ST_SLEEP = 4'b0010,
        ST_ISOLATION = 4'b0100,
        ST_CONFIG = 4'b1000
    } iccr_state_type;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] index;
        logic [7:0] data;
    } iccr_access_type;

    typedef struct packed {
        logic reset_devices;
        logic wait_for_key;
        logic clear_csn;
    } iccr_cmd_type;
endpackage

/* verif/iccr_regs_properties.sv */
module iccr_properties (
    input wire logic REF_CLK, SYS_RST, CLK_EN, CFG_WR, CFG_RD, SERIAL_ID_STEP,
    input wire logic [7:0] CFG_INDEX, CFG_WDATA, CFG_RDATA, CARD_SELECT_NUMBER,
    input wire logic [9:0] READ_PORT_ADDR,
    input wire logic [1:0] DEVICE_RESET,
    input wire logic [3:0] CARD_STATE
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking dc @(posedge REF_CLK); endclocking
    default disable iff (SYS_RST);
    wire logic w = CLK_EN && CFG_WR;
    wire logic c = w && CFG_INDEX == 8'h02;
    sequence s_pulse;
        DEVICE_RESET == 2'b11 ##1 DEVICE_RESET == 2'b00;
    endsequence
    chk_reloc_addr: assert property (w && CFG_INDEX == 0
        |=> READ_PORT_ADDR == {$past(CFG_WDATA), 2'b11}) else $error("addr");
    chk_zero_read: assert property (CLK_EN && CFG_RD && CFG_INDEX < 8'h30
        && !(CFG_INDEX inside {1, 4, 5}) |=> CFG_RDATA == 0) else $error("read");
    chk_id_step: assert property (CLK_EN && CFG_RD && CFG_INDEX == 1
        |=> SERIAL_ID_STEP == ($past(CARD_STATE) == 4)) else $error("step");
    chk_id_ignore: assert property (w && CFG_INDEX == 1
        |=> $stable(READ_PORT_ADDR)) else $error("id");
    chk_dev_pulse: assert property (c && CFG_WDATA[0]
        |=> s_pulse) else $error("pulse");
    chk_dev_quiet: assert property (c && !CFG_WDATA[0]
        |=> DEVICE_RESET == 0) else $error("dev");
    chk_key_wait: assert property (c && CFG_WDATA[1]
        |=> CARD_STATE == 1) else $error("key");
    chk_csn_clear: assert property (c && CFG_WDATA[2]
        |=> CARD_SELECT_NUMBER == 0) else $error("csn");
endmodule
bind iccr_regs iccr_properties i_chk (.*);

/* verif/iccr_host.sv */
module iccr_host (
    input wire logic REF_CLK, input wire logic [7:0] CFG_RDATA,
    output logic CFG_WR, CFG_RD, output logic [7:0] CFG_INDEX, CFG_WDATA
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {CFG_WR, CFG_RD, CFG_INDEX, CFG_WDATA} = '0;
    // released index and data lines show the inverse of what was sent
    task automatic acc(input logic w, input logic [7:0] i, d, output logic [7:0] q);
        @(posedge REF_CLK) #1 {CFG_WR, CFG_RD, CFG_INDEX, CFG_WDATA} = {w, !w, i, d};
        @(posedge REF_CLK) #1 {CFG_WR, CFG_RD, CFG_INDEX, CFG_WDATA} = {2'b00, ~i, ~d};
        q = CFG_RDATA;
    endtask
endmodule

/* verif/tb_isa_card_config_control_regs.sv */
module tb_isa_card_config_control_regs;
    timeunit 1ns;
    timeprecision 1ns;
    logic REF_CLK = 0, SYS_RST = 1, KEY_MATCHED = 0, CARD_SELECT_NUMBER_LOAD = 0;
    logic CLK_EN = 1, RESOURCE_READY = 0, RESOURCE_ADVANCE, RESOURCE_PTR_RESET;
    logic CFG_WR, CFG_RD, SERIAL_ID_STEP;
    logic [7:0] q, CFG_INDEX, CFG_WDATA, CFG_RDATA, CARD_SELECT_NUMBER;
    logic [9:0] READ_PORT_ADDR;
    logic [1:0] DEVICE_RESET;
    logic [3:0] CARD_STATE;
    int error_cnt = 0, num_checks = 0, cyc = 0;
    always #25 REF_CLK = ~REF_CLK;
    iccr_host i_host (.*);
    iccr_regs i_dut (.*, .CARD_SELECT_NUMBER_IN(8'h07), .RESOURCE_BYTE(8'h5a),
        .SERIAL_ID_BYTE(8'h3c));
    task automatic chk(input logic [15:0] s, e);
        num_checks++;
        if (s !== e) $display("ERROR %0t seen %h expected %h", $time, s, e);
        error_cnt += int'(s !== e);
    endtask
    task automatic close_out;
        if (cyc >= 400) error_cnt++;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic t_regs;
        i_host.acc(1, 8'h00, 8'ha5, q);
        chk(READ_PORT_ADDR, 10'h297);
        for (int k = 0; k < 48; k++) if (!(k inside {4, 5})) begin
            i_host.acc(0, 8'(k), 8'h5a, q);
            chk(q, 8'h00);
        end
        i_host.acc(1, 8'h01, 8'h11, q);
        chk(READ_PORT_ADDR, 10'h297);
        $display("t_regs done");
    endtask
    task automatic t_ctl;
        @(posedge REF_CLK) #1 KEY_MATCHED = 1;
        @(posedge REF_CLK) #1 KEY_MATCHED = 0;
        i_host.acc(1, 8'h03, 8'h00, q);
        chk(CARD_STATE, 4'h4);
        i_host.acc(0, 8'h01, 8'h00, q);
        chk(SERIAL_ID_STEP, 1'b1);
        chk(q, 8'h3c);
        @(posedge REF_CLK) #1 CARD_SELECT_NUMBER_LOAD = 1;
        @(posedge REF_CLK) #1 CARD_SELECT_NUMBER_LOAD = 0;
        i_host.acc(1, 8'h02, 8'h03, q);
        chk({CARD_STATE, CARD_SELECT_NUMBER, DEVICE_RESET}, 14'h041f);
        i_host.acc(1, 8'h02, 8'h04, q);
        chk({CARD_STATE, CARD_SELECT_NUMBER}, 12'h100);
        $display("t_ctl done");
    endtask
    task automatic t_res;
        chk(READ_PORT_ADDR, 10'h003);
        @(posedge REF_CLK) #1 CLK_EN = 0;
        i_host.acc(1, 8'h00, 8'hff, q);
        chk(READ_PORT_ADDR, 10'h003);
        @(posedge REF_CLK) #1 CLK_EN = 1;
        @(posedge REF_CLK) #1 KEY_MATCHED = 1;
        @(posedge REF_CLK) #1 KEY_MATCHED = 0;
        @(posedge REF_CLK) #1 CARD_SELECT_NUMBER_LOAD = 1;
        @(posedge REF_CLK) #1 CARD_SELECT_NUMBER_LOAD = 0;
        i_host.acc(1, 8'h03, 8'h07, q);
        chk({CARD_STATE, 3'b000, RESOURCE_PTR_RESET}, 8'h81);
        i_host.acc(0, 8'h05, 8'h00, q);
        chk(q, 8'h00);
        @(posedge REF_CLK) #1 RESOURCE_READY = 1;
        i_host.acc(0, 8'h05, 8'h00, q);
        chk(q, 8'h01);
        i_host.acc(0, 8'h04, 8'h00, q);
        chk({q, 7'h00, RESOURCE_ADVANCE}, 16'h5a01);
        $display("t_res done");
    endtask
    initial begin
        repeat (16) @(posedge REF_CLK);
        #1 SYS_RST = 0;
        t_regs;
        t_ctl;
        t_res;
        close_out;
    end
    always @(posedge REF_CLK) if (++cyc == 400) close_out;
endmodule
